// >>> logic/instr_fetch_port.sv
// external instruction fetch port of a four-bit evaluator core.
// assumes an external memory answers INSTR_IN from the driven address
// within five oscillator phases; all inputs are synchronous to MCLK.
`timescale 1ns/1ns
`include "fetch_port_map.svh"

module instr_fetch_port (
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    input  wire logic        INIT,
    input  wire logic        CHAPTER_EN,
    input  wire logic [15:0] STROBE_ENABLE,
    input  wire logic [7:0]  INSTR_IN,
    input  wire logic [3:0]  KEY_IN,
    output logic      [5:0]  PROG_COUNTER,
    output logic      [3:0]  PAGE_ADDR,
    output logic             CHAPTER_ADDR,
    output logic      [3:0]  DATA_OUT,
    output logic             STATUS_LATCH_OUT,
    output logic      [15:0] STROBE_LATCH_OUT
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fetch_pkg::phase_e      phase;
    fetch_pkg::phase_e      next_phase;
    logic [5:0]             div_cnt;
    logic [5:0]             next_div_cnt;
    fetch_pkg::instr_addr_s addr;
    fetch_pkg::instr_addr_s next_addr;
    logic [3:0]             page_buf;
    logic [3:0]             next_page_buf;
    logic                   chapter_buf;
    logic                   next_chapter_buf;
    logic                   status;
    logic                   next_status;
    logic [3:0]             acc;
    logic [3:0]             next_acc;
    logic [3:0]             y_reg;
    logic [3:0]             next_y_reg;
    logic [7:0]             instr;
    logic [7:0]             next_instr;
    fetch_pkg::out_reg_s    out_reg;
    fetch_pkg::out_reg_s    next_out_reg;
    logic [15:0]            strobe;
    logic [15:0]            next_strobe;
    logic                   tick;
    logic                   exec;
    logic [5:0]             seq_count;

    // one phase every oscillator period of MCLK cycles
    assign tick = (div_cnt == 6'(`PHASE_CYCLES - 1));
    assign exec = tick && (phase == fetch_pkg::PH_EXEC);

    pc_sequencer u_seq (
        .count      (addr.count),
        .next_count (seq_count)
    );

    // ------------------------------------------------------------
    // next-state: phase divider, fetch and execute
    // ------------------------------------------------------------
    always_comb begin
        next_phase       = phase;
        next_div_cnt     = tick ? 6'h00 : div_cnt + 6'h01;
        next_addr        = addr;
        next_page_buf    = page_buf;
        next_chapter_buf = chapter_buf;
        next_status      = status;
        next_acc         = acc;
        next_y_reg       = y_reg;
        next_instr       = instr;
        next_out_reg     = out_reg;
        next_strobe      = strobe;
        if (INIT) begin
            // init behaves as a power-on clear, except that the instruction register keeps its value
            next_phase         = fetch_pkg::PH_ADDR;
            next_div_cnt       = 6'h00;
            next_addr.count    = `COUNT_RESET;
            next_addr.page     = `PAGE_RESET;
            next_addr.chapter  = `CHAPTER_RESET;
            next_page_buf      = `PAGE_RESET;
            next_chapter_buf   = `CHAPTER_RESET;
            next_status        = 1'b1;
            next_acc           = 4'h0;
            next_y_reg         = 4'h0;
            next_out_reg       = `OUT_RESET;
            next_strobe        = `STROBE_RESET;
        end else if (tick) begin
            case (phase)
                fetch_pkg::PH_ADDR:  next_phase = fetch_pkg::PH_1;
                fetch_pkg::PH_1:     next_phase = fetch_pkg::PH_2;
                fetch_pkg::PH_2:     next_phase = fetch_pkg::PH_3;
                fetch_pkg::PH_3:     next_phase = fetch_pkg::PH_LATCH;
                fetch_pkg::PH_LATCH: next_phase = fetch_pkg::PH_EXEC;
                fetch_pkg::PH_EXEC:  next_phase = fetch_pkg::PH_ADDR;
                default:             next_phase = fetch_pkg::PH_ADDR;
            endcase
            // late sample gives the memory five phases of settled address
            if (phase == fetch_pkg::PH_LATCH) begin
                next_instr = INSTR_IN;
            end
            if (phase == fetch_pkg::PH_EXEC) begin
                next_status     = 1'b1;
                next_addr.count = seq_count;
                if (instr[7:6] == `BRANCH_HI) begin
                    // branch only when the previous status left it set
                    if (status) begin
                        next_addr.count   = instr[5:0];
                        next_addr.page    = page_buf;
                        next_addr.chapter = CHAPTER_EN & chapter_buf;
                    end
                end else if (instr[7:4] == `OP_LOAD_PAGE) begin
                    next_page_buf = instr[`IMM_LO:0];
                end else if (instr[7:4] == `OP_LOAD_Y) begin
                    next_y_reg = instr[`IMM_LO:0];
                end else if (instr[7:4] == `OP_LOAD_ACC) begin
                    next_acc = instr[`IMM_LO:0];
                end else begin
                    case (instr)
                        `OP_KEY_TO_ACC:   next_acc = KEY_IN;
                        `OP_KEY_NONZERO:  next_status = (KEY_IN != 4'h0);
                        `OP_TO_OUT: begin
                            next_out_reg.data   = acc;
                            next_out_reg.status = status;
                        end
                        `OP_CLEAR_OUT:    next_out_reg = `OUT_RESET;
                        // latches not enabled by the user stay low
                        `OP_SET_STROBE:   next_strobe[y_reg] = STROBE_ENABLE[y_reg];
                        `OP_RESET_STROBE: next_strobe[y_reg] = 1'b0;
                        `OP_TOGGLE_CHAP:  next_chapter_buf = ~chapter_buf;
                        default:          next_status = 1'b1;
                    endcase
                end
                // the strap may drop after a chapter was entered; the smaller
                // variant must not keep driving that bit past the next execute
                if (!CHAPTER_EN) begin
                    next_addr.chapter = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            phase       <= fetch_pkg::PH_ADDR;
            div_cnt     <= 6'h00;
            addr        <= {`CHAPTER_RESET, `PAGE_RESET, `COUNT_RESET};
            page_buf    <= `PAGE_RESET;
            chapter_buf <= `CHAPTER_RESET;
            status      <= 1'b1;
            acc         <= 4'h0;
            y_reg       <= 4'h0;
            instr       <= 8'h00;
            out_reg     <= `OUT_RESET;
            strobe      <= `STROBE_RESET;
        end else begin
            phase       <= next_phase;
            div_cnt     <= next_div_cnt;
            addr        <= next_addr;
            page_buf    <= next_page_buf;
            chapter_buf <= next_chapter_buf;
            status      <= next_status;
            acc         <= next_acc;
            y_reg       <= next_y_reg;
            instr       <= next_instr;
            out_reg     <= next_out_reg;
            strobe      <= next_strobe;
        end
    end

    // ------------------------------------------------------------
    // outputs: dedicated address and data pins, all straight from flops
    // ------------------------------------------------------------
    assign PROG_COUNTER     = addr.count;
    assign PAGE_ADDR        = addr.page;
    assign CHAPTER_ADDR     = addr.chapter;
    assign DATA_OUT         = out_reg.data;
    assign STATUS_LATCH_OUT = out_reg.status;
    assign STROBE_LATCH_OUT = strobe;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    a_addr_hold: assert property (!exec && !INIT |=> $stable(addr))
        else $error("address moved outside the execute edge");
    a_instr_late: assert property (tick && phase == fetch_pkg::PH_LATCH && !INIT
                                   |=> instr == $past(INSTR_IN))
        else $error("instruction not latched in the late phase");
    a_seq_step: assert property (exec && !INIT && instr[7:6] != `BRANCH_HI
                                 |=> addr.count == $past(seq_count))
        else $error("counter did not take its sequenced value");
    a_branch_page: assert property (exec && !INIT && status && instr[7:6] == `BRANCH_HI
                                    |=> addr.page == $past(page_buf) && addr.count == $past(instr[5:0]))
        else $error("taken branch did not load page and counter");
    a_small_chap: assert property (!CHAPTER_EN && exec && !INIT |=> !CHAPTER_ADDR)
        else $error("chapter bit driven on smaller variant");
    a_out_copy: assert property (exec && !INIT && instr == `OP_TO_OUT
                                 |=> DATA_OUT == $past(acc) && STATUS_LATCH_OUT == $past(status))
        else $error("output register not copied untranslated");
    a_key_take: assert property (exec && !INIT && instr == `OP_KEY_TO_ACC
                                 |=> acc == $past(KEY_IN))
        else $error("key inputs not taken into accumulator");
    a_strobe_set: assert property (exec && !INIT && instr == `OP_SET_STROBE
                                   |=> STROBE_LATCH_OUT[$past(y_reg)] == $past(STROBE_ENABLE[y_reg]))
        else $error("strobe latch not set as enabled");
    a_init_clear: assert property (INIT |=> PROG_COUNTER == `COUNT_RESET && PAGE_ADDR == `PAGE_RESET
                                   && STROBE_LATCH_OUT == `STROBE_RESET && DATA_OUT == 4'h0)
        else $error("init did not clear the device");
    a_phase_span: assert property (tick && phase == fetch_pkg::PH_ADDR && !INIT
                                   ##1 (!INIT) [*8] |-> $stable(addr))
        else $error("address unstable early in the cycle");

    c_branch:  cover property (exec && status && instr[7:6] == `BRANCH_HI);
    c_out:     cover property (exec && instr == `OP_TO_OUT);
    c_strobe:  cover property (exec && instr == `OP_SET_STROBE && STROBE_ENABLE[y_reg]);
    c_key:     cover property (exec && instr == `OP_KEY_NONZERO && KEY_IN != 4'h0);

endmodule // instr_fetch_port

// >>> logic/fetch_port_map.svh
// constants for the external instruction fetch port: timing counts,
// reset values and instruction encodings.
// assumes MCLK at 20 MHz; included by bare name wherever needed.
`ifndef FETCH_PORT_MAP_SVH
`define FETCH_PORT_MAP_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define MCLK_PERIOD_NS   50
`define OSC_PERIOD_NS    3000
// least time, so rounded up to whole MCLK cycles
`define PHASE_CYCLES     ((`OSC_PERIOD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define COUNT_RESET      6'h00
`define PAGE_RESET       4'hf
`define CHAPTER_RESET    1'h0
`define STROBE_RESET     16'h0000
`define OUT_RESET        5'h00

// ------------------------------------------------------------
// instruction encodings (field positions and opcodes)
// ------------------------------------------------------------
`define BRANCH_HI        2'h2
`define IMM_LO           3
`define OP_LOAD_PAGE     4'h1
`define OP_LOAD_Y        4'h4
`define OP_LOAD_ACC      4'h6
`define OP_KEY_TO_ACC    8'h08
`define OP_KEY_NONZERO   8'h09
`define OP_TO_OUT        8'h0a
`define OP_CLEAR_OUT     8'h0b
`define OP_RESET_STROBE  8'h0c
`define OP_SET_STROBE    8'h0d
`define OP_TOGGLE_CHAP   8'h0e

`endif

// >>> logic/fetch_pkg.sv
// types shared by the instruction fetch port and its memory model.
// assumes fetch_port_map.svh holds all numeric constants.
package fetch_pkg;

    // ------------------------------------------------------------
    // address driven to the external instruction memory
    // ------------------------------------------------------------
    typedef struct packed {
        logic       chapter;
        logic [3:0] page;
        logic [5:0] count;
    } instr_addr_s;

    // ------------------------------------------------------------
    // latched data output register
    // ------------------------------------------------------------
    typedef struct packed {
        logic       status;
        logic [3:0] data;
    } out_reg_s;

    // six phases of one instruction cycle
    typedef enum {
        PH_ADDR,
        PH_1,
        PH_2,
        PH_3,
        PH_LATCH,
        PH_EXEC
    } phase_e;

endpackage

// >>> logic/pc_sequencer.sv
// next-value function of the six-bit instruction counter.
// assumes the caller registers the result once per instruction cycle.
`timescale 1ns/1ns

module pc_sequencer (
    input  wire logic [5:0] count,
    output logic      [5:0] next_count
);

    // ------------------------------------------------------------
    // shift with xnor feedback; the lock-up value is steered to zero
    // so a branch onto it cannot stall the counter
    // ------------------------------------------------------------
    always_comb begin
        if (count == 6'h3f) begin
            next_count = 6'h00;
        end else begin
            next_count = {count[4:0], ~(count[5] ^ count[4])};
        end
    end

endmodule // pc_sequencer

// >>> testbench/instr_memory_model.sv
// behavioural external instruction memory facing the fetch port.
// assumes the bench fills mem before it releases the port from reset.
`timescale 1ns/1ns

module instr_memory_model #(
    parameter int SETTLE_CYCLES = 250
) (
    input  wire logic                   mclk,
    input  wire fetch_pkg::instr_addr_s addr,
    output logic                  [7:0] instr
);
    logic [7:0]             mem [0:2047];
    fetch_pkg::instr_addr_s last_addr;
    int unsigned            settle;

    // ------------------------------------------------------------
    // lookup with access time
    // ------------------------------------------------------------
    // output toggles while settling, so an early latch sees the stale word or its inverse
    initial instr = 8'h5a;
    always @(posedge mclk) begin
        if (addr !== last_addr) begin
            last_addr <= addr;
            settle    <= 0;
            instr     <= ~instr;
        end else if (settle < SETTLE_CYCLES) begin
            settle <= settle + 1;
            instr  <= ~instr;
        end else begin
            instr <= mem[11'(addr)];
        end
    end
endmodule // instr_memory_model

// >>> testbench/instr_fetch_port_tb.sv
// self-checking bench for the instruction fetch port and its memory model.
// assumes MCLK at 20 MHz and one instruction every 360 clocks.
`timescale 1ns/1ns
`include "fetch_port_map.svh"

module instr_fetch_port_tb;
    logic        mclk          = 1'b0;
    logic        rst_b         = 1'b0;
    logic        init          = 1'b0;
    logic        chapter_en    = 1'b1;
    logic [15:0] strobe_enable = 16'h0000;
    logic [3:0]  key           = 4'h0;
    logic [7:0]  instr;
    logic [5:0]  pc;
    logic [3:0]  page;
    logic        chap;
    logic [3:0]  data;
    logic        status;
    logic [15:0] strobes;
    int          fails         = 0;
    int          n_compared    = 0;

    always #25 mclk = ~mclk;

    instr_fetch_port uut (.MCLK(mclk), .RST_B(rst_b), .INIT(init), .CHAPTER_EN(chapter_en),
        .STROBE_ENABLE(strobe_enable), .INSTR_IN(instr), .KEY_IN(key), .PROG_COUNTER(pc),
        .PAGE_ADDR(page), .CHAPTER_ADDR(chap), .DATA_OUT(data), .STATUS_LATCH_OUT(status),
        .STROBE_LATCH_OUT(strobes));
    // slow memory: answers 250 clocks after each address change
    instr_memory_model #(.SETTLE_CYCLES(250)) mem_i (.mclk(mclk), .addr({chap, page, pc}), .instr(instr));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [5:0] step_count(input logic [5:0] c);
        return (c == 6'h3f) ? 6'h00 : {c[4:0], ~(c[5] ^ c[4])};
    endfunction

    // program sits on the reset page in counter order; ends mid first cycle
    task automatic restart(input logic [7:0] prog[$]);
        logic [5:0] c;
        @(negedge mclk);
        rst_b = 1'b0;
        c = `COUNT_RESET;
        for (int i = 0; i < 2048; i++)
            mem_i.mem[i] = 8'h00;
        foreach (prog[i]) begin
            mem_i.mem[{1'b0, `PAGE_RESET, c}] = prog[i];
            c = step_count(c);
        end
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        repeat (180) @(negedge mclk);
    endtask

    task automatic run(input int n);
        repeat (360 * n) @(negedge mclk);
    endtask

    task automatic check_idle();
        check("count", 16'(`COUNT_RESET), 16'(pc));
        check("page", 16'(`PAGE_RESET), 16'(page));
        check("outs", 16'h0000, {chap, status, data, strobes[9:0]});
        check("strobes", `STROBE_RESET, strobes);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_init();
        strobe_enable = 16'hffff;
        restart('{8'h4f, `OP_SET_STROBE, 8'h65, `OP_TO_OUT});
        check_idle();
        run(4);
        check("strobes set", 16'h8000, strobes);
        init = 1'b1;
        @(negedge mclk);
        init = 1'b0;
        @(negedge mclk);
        check_idle();
        repeat (539) @(negedge mclk);
        check("count after init", 16'h0001, 16'(pc));
    endtask

    task automatic t_sequence();
        logic [5:0] c;
        c = `COUNT_RESET;
        restart('{8'h00});
        for (int k = 0; k < 8; k++) begin
            check("count", 16'(c), 16'(pc));
            check("page", 16'(`PAGE_RESET), 16'(page));
            repeat (170) @(negedge mclk);
            check("count held", 16'(c), 16'(pc));
            repeat (190) @(negedge mclk);
            c = step_count(c);
        end
    endtask

    task automatic t_keys();
        key = 4'h9;
        restart('{`OP_KEY_TO_ACC, `OP_TO_OUT, `OP_KEY_NONZERO, `OP_TO_OUT, 8'h65, `OP_TO_OUT, `OP_CLEAR_OUT});
        run(2);
        check("data key", 16'h0009, 16'(data));
        check("status set", 16'h0001, 16'(status));
        key = 4'h0;
        run(2);
        check("status clear", 16'h0000, 16'(status));
        check("data kept", 16'h0009, 16'(data));
        run(2);
        check("data imm", 16'h0005, 16'(data));
        run(1);
        check("data cleared", 16'h0000, 16'(data));
    endtask

    task automatic t_strobe();
        strobe_enable = 16'h8001;
        restart('{8'h4f, `OP_SET_STROBE, 8'h40, `OP_SET_STROBE, 8'h43, `OP_SET_STROBE, 8'h4f, `OP_RESET_STROBE});
        run(6);
        check("strobes set", 16'h8001, strobes);
        run(2);
        check("strobe reset", 16'h0001, strobes);
    endtask

    task automatic t_branch();
        chapter_en = 1'b1;
        restart('{8'h12, `OP_TOGGLE_CHAP, 8'haa});
        // reached in sequence after the strap drops, so the chapter bit is low by then
        mem_i.mem[{1'b0, 4'h2, 6'h14}] = 8'h95;
        run(3);
        check("branch count", 16'h002a, 16'(pc));
        check("branch page", 16'h0002, 16'(page));
        check("chapter large", 16'h0001, 16'(chap));
        chapter_en = 1'b0;
        run(2);
        check("branch count", 16'h0015, 16'(pc));
        check("chapter small", 16'h0000, 16'(chap));
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // whole run needs about 13000 clocks
    initial begin
        repeat (30000) @(posedge mclk);
        fails++;
        summarize();
    end

    initial begin
        t_reset_init();
        t_sequence();
        t_keys();
        t_strobe();
        t_branch();
        summarize();
    end
endmodule // instr_fetch_port_tb
